// ---- logic/sa_map.vh ----
// register offsets, field positions, reset values and timing counts
// for the stepper output and axis enable block; definitions only
`ifndef SA_MAP_VH
`define SA_MAP_VH

// register byte offsets
`define SA_OFF_ENABLE    8'h00
`define SA_OFF_STATUS    8'h04
`define SA_OFF_EXTRA_ENC 8'h08
`define SA_MAP_BASE_HI   3'h1
`define SA_OCFG_BASE_HI  4'h4
`define SA_ACFG_BASE_HI  3'h3

// enable command fields
`define SA_EN_MAP_MSB    7
`define SA_EN_CODE_LSB   8
`define SA_EN_CODE_MSB   10
`define SA_CODE_RST      3'h3

// status fields
`define SA_ERR_RATE      0
`define SA_ERR_MODE      1
`define SA_ERR_ILLEGAL   2

// axis resource map fields
`define SA_MAP_OUT_MSB   1
`define SA_MAP_STEP      2
`define SA_MAP_FB1       3
`define SA_MAP_FB2       4
`define SA_MAP_RST       5'h00

// stepper output config fields
`define SA_CFG_MODE      0
`define SA_CFG_POL       1
`define SA_CFG_RST       2'h2

// axi responses
`define SA_RESP_OKAY     2'h0
`define SA_RESP_SLVERR   2'h2

// timing: base period in units of 100 ns, clock in MHz
`define SA_BASE_PERIOD_100NS 625
`define SA_CLK_MHZ           200
`define SA_BASE_CYCLES       ((`SA_BASE_PERIOD_100NS * `SA_CLK_MHZ) / 10)

`endif

// ---- logic/sa_step_out.v ----
// one stepper output pair: step/direction or dual pulse, with polarity
// assumes tick is a one-cycle pulse and req/fwd are held by the caller
`timescale 1ns/1ps

module sa_step_out (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // control
  input  wire tick,
  input  wire enable,
  input  wire mode_dual,
  input  wire pol_low,
  input  wire req,
  input  wire fwd,
  // pins
  output reg  pin_a,
  output reg  pin_b
);

  reg  pulse_reg;
  reg  dir_reg;
  wire act_a;
  wire act_b;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_reg <= 1'b0;
      dir_reg   <= 1'b1;
    end else if (tick) begin
      // one tick high, then one tick idle
      if (pulse_reg) begin
        pulse_reg <= 1'b0;
      end else if (enable && req) begin
        pulse_reg <= 1'b1;
        dir_reg   <= fwd;
      end
    end
  end

  // step pulses on a, direction level on b
  // dual mode pulses a forward, b reverse
  assign act_a = mode_dual ? (pulse_reg & dir_reg) : pulse_reg;
  assign act_b = mode_dual ? (pulse_reg & ~dir_reg) : dir_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_a <= 1'b1;
      pin_b <= 1'b0;
    end else begin
      // active low drives pin low when asserted
      // polarity sets idle and direction sense
      pin_a <= pol_low ? ~act_a : act_a;
      pin_b <= pol_low ? ~act_b : act_b;
    end
  end

endmodule // sa_step_out

// ---- logic/sa_tick.v ----
// update tick divider: one-cycle tick every (code + 1) base periods
// assumes a single clock; base_cycles comes from the top module
`timescale 1ns/1ps

module sa_tick #(
  parameter BASE_CYCLES = 12500
) (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // period code
  input  wire [2:0] code,
  // tick out
  output reg        tick
);

  reg  [15:0] base_cnt_reg;
  reg  [2:0]  per_cnt_reg;
  wire        base_wrap;

  assign base_wrap = (base_cnt_reg == BASE_CYCLES[15:0] - 16'h0001);

  always @(posedge aclk) begin
    if (!aresetn) begin
      base_cnt_reg <= 16'h0000;
      per_cnt_reg  <= 3'h0;
      tick         <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (base_wrap) begin
        base_cnt_reg <= 16'h0000;
        // a shortened code takes effect at the next base period
        if (per_cnt_reg >= code) begin
          per_cnt_reg <= 3'h0;
          tick        <= 1'b1;
        end else begin
          per_cnt_reg <= per_cnt_reg + 3'h1;
        end
      end else begin
        base_cnt_reg <= base_cnt_reg + 16'h0001;
      end
    end
  end

endmodule // sa_tick

// ---- logic/sa_top.v ----
// stepper output stage and axis enable / update rate control,
// reached over axi4-lite; assumes axis_active comes from the motion core
//
// Behaviour
// - per-output polarity, active low by default
// - assert drives pin low or high
// - step/dir: pulses on a, direction on b
// - dual mode: a forward, b reverse
// - polarity sets direction sense and idle level
// - mode and polarity persist, rewritable anytime
// - axis-addressed config reaches mapped output
// - eight-bit enable bitmap, reset disabled
// - period code 0 to 7, default 3
// - period is (code plus one) times 62.5us
// - step generator refreshed on that tick
// - only enabled axes get updates
// - minimum period grows with enabled axes
// - too-fast rate flags error, keeps previous
// - fastest rate needs single-feedback servos only
// - enabling axis enables its feedback devices
// - disabling an active axis gives wrong-mode error
// - illegal axis cannot be enabled, flags error
`timescale 1ns/1ps
`include "sa_map.vh"

module sa_top #(
  parameter BASE_CYCLES   = `SA_BASE_CYCLES,
  parameter LARGE_VARIANT = 0
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // motion core
  input  wire [7:0]  axis_active,
  input  wire [3:0]  step_req,
  input  wire [3:0]  step_fwd,
  output wire        loop_tick,
  output reg  [7:0]  axis_update,
  // feedback enables
  output reg  [7:0]  fb_primary_en,
  output reg  [7:0]  fb_secondary_en,
  // stepper driver pins
  output wire [3:0]  step_a,
  output wire [3:0]  step_b
);

  ////////////////////////////////////////////////////////////////////
  // state

  reg  [7:0]  en_reg;
  reg  [2:0]  code_reg;
  reg  [2:0]  err_reg;
  reg  [3:0]  extra_enc_reg;
  reg  [4:0]  map_reg [0:7];
  reg  [1:0]  ocfg_reg [0:3];

  reg         aw_full_reg;
  reg  [7:0]  aw_addr_reg;
  reg         w_full_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;

  integer     i, j, k, m;

  ////////////////////////////////////////////////////////////////////
  // axi write side: address and data taken in either order

  wire do_wr;

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign do_wr         = aw_full_reg & w_full_reg & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_wr) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write decode

  wire       wr_any;
  wire       hit_en;
  wire       hit_st;
  wire       hit_xe;
  wire       hit_map;
  wire       hit_ocfg;
  wire       hit_acfg;
  wire [2:0] wr_idx;
  wire       wr_hit;

  assign wr_any   = do_wr & (|w_strb_reg);
  assign hit_en   = (aw_addr_reg == `SA_OFF_ENABLE);
  assign hit_st   = (aw_addr_reg == `SA_OFF_STATUS);
  assign hit_xe   = (aw_addr_reg == `SA_OFF_EXTRA_ENC);
  assign hit_map  = (aw_addr_reg[7:5] == `SA_MAP_BASE_HI);
  assign hit_ocfg = (aw_addr_reg[7:4] == `SA_OCFG_BASE_HI);
  assign hit_acfg = (aw_addr_reg[7:5] == `SA_ACFG_BASE_HI);
  assign wr_idx   = aw_addr_reg[4:2];
  assign wr_hit   = hit_en | hit_st | hit_xe | hit_map | hit_ocfg | hit_acfg;

  ////////////////////////////////////////////////////////////////////
  // enable command check

  wire [7:0] new_en;
  wire [2:0] new_code;
  reg  [3:0] cnt;
  reg  [3:0] units;
  reg  [3:0] min_code;
  reg        fast_ok;
  reg  [7:0] servo_nofb;
  wire       bad_mode;
  wire       bad_illegal;
  wire       bad_rate;

  assign new_en   = w_data_reg[`SA_EN_MAP_MSB:0];
  assign new_code = w_data_reg[`SA_EN_CODE_MSB:`SA_EN_CODE_LSB];

  always @* begin
    cnt        = 4'h0;
    fast_ok    = (extra_enc_reg == 4'h0);
    servo_nofb = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (new_en[i]) begin
        cnt = cnt + 4'h1;
        // stepper or dual feedback loses the fastest rate
        if (map_reg[i][`SA_MAP_STEP] || map_reg[i][`SA_MAP_FB2]) begin
          fast_ok = 1'b0;
        end
        servo_nofb[i] = ~map_reg[i][`SA_MAP_STEP] & ~map_reg[i][`SA_MAP_FB1];
      end
    end
    // one period step per axis, or per pair on the large variant
    units = (LARGE_VARIANT != 0) ? ((cnt + 4'h1) >> 1) : cnt;
    min_code = (units == 4'h0) ? 4'h0 : units - 4'h1;
    if (min_code == 4'h0 && units != 4'h0 && !fast_ok) begin
      min_code = 4'h1;
    end
  end

  // clearing a bit of a still active axis
  assign bad_mode    = |(en_reg & ~new_en & axis_active);
  // servo axis with no primary feedback mapped
  assign bad_illegal = |servo_nofb;
  assign bad_rate    = ({1'b0, new_code} < min_code);

  wire en_cmd;
  wire en_ok;

  assign en_cmd = wr_any & hit_en;
  assign en_ok  = ~bad_mode & ~bad_illegal & ~bad_rate;

  ////////////////////////////////////////////////////////////////////
  // register writes

  wire [2:0] err_set;
  wire [2:0] err_clr;
  wire [1:0] acfg_out;

  assign err_set = en_cmd ? {bad_illegal, bad_mode, bad_rate & ~bad_mode & ~bad_illegal}
                          : 3'h0;
  assign err_clr = (wr_any & hit_st) ? w_data_reg[2:0] : 3'h0;
  assign acfg_out = map_reg[wr_idx][`SA_MAP_OUT_MSB:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      en_reg        <= 8'h00;
      code_reg      <= `SA_CODE_RST;
      err_reg       <= 3'h0;
      extra_enc_reg <= 4'h0;
      for (j = 0; j < 8; j = j + 1) begin
        map_reg[j] <= `SA_MAP_RST;
      end
      for (j = 0; j < 4; j = j + 1) begin
        ocfg_reg[j] <= `SA_CFG_RST;
      end
    end else begin
      // a refused command keeps rate and enables
      if (en_cmd && en_ok) begin
        en_reg   <= new_en;
        code_reg <= new_code;
      end
      // set wins over a simultaneous clear
      err_reg <= (err_reg & ~err_clr) | err_set;
      if (wr_any && hit_xe) begin
        extra_enc_reg <= w_data_reg[3:0];
      end
      // remapping ignored while any axis is enabled
      if (wr_any && hit_map && en_reg == 8'h00) begin
        map_reg[wr_idx] <= w_data_reg[4:0];
      end
      if (wr_any && hit_ocfg) begin
        ocfg_reg[wr_idx[1:0]] <= w_data_reg[1:0];
      end
      // axis-addressed config lands on its mapped output
      if (wr_any && hit_acfg) begin
        ocfg_reg[acfg_out] <= w_data_reg[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write response

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SA_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `SA_RESP_OKAY : `SA_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read side

  reg [31:0] rd_data;
  reg        rd_hit;

  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr == `SA_OFF_ENABLE) begin
      rd_data = {21'h00_0000, code_reg, en_reg};
    end else if (s_axi_araddr == `SA_OFF_STATUS) begin
      rd_data = {13'h0000, code_reg, en_reg, 5'h00, err_reg};
    end else if (s_axi_araddr == `SA_OFF_EXTRA_ENC) begin
      rd_data = {28'h000_0000, extra_enc_reg};
    end else if (s_axi_araddr[7:5] == `SA_MAP_BASE_HI) begin
      rd_data = {27'h000_0000, map_reg[s_axi_araddr[4:2]]};
    end else if (s_axi_araddr[7:4] == `SA_OCFG_BASE_HI) begin
      rd_data = {30'h0000_0000, ocfg_reg[s_axi_araddr[3:2]]};
    end else if (s_axi_araddr[7:5] == `SA_ACFG_BASE_HI) begin
      rd_data = {30'h0000_0000, ocfg_reg[map_reg[s_axi_araddr[4:2]][1:0]]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SA_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_hit ? `SA_RESP_OKAY : `SA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // update tick and axis servicing

  wire tick;

  // base period times (code + 1)
  sa_tick #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .code    (code_reg),
    .tick    (tick)
  );

  assign loop_tick = tick;

  always @(posedge aclk) begin
    if (!aresetn) begin
      axis_update     <= 8'h00;
      fb_primary_en   <= 8'h00;
      fb_secondary_en <= 8'h00;
    end else begin
      // updates go to enabled axes only
      axis_update <= tick ? en_reg : 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        fb_primary_en[k]   <= en_reg[k] & map_reg[k][`SA_MAP_FB1];
        fb_secondary_en[k] <= en_reg[k] & map_reg[k][`SA_MAP_FB2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // stepper outputs

  reg [3:0] out_en;

  always @* begin
    out_en = 4'h0;
    for (m = 0; m < 8; m = m + 1) begin
      if (en_reg[m] && map_reg[m][`SA_MAP_STEP]) begin
        out_en[map_reg[m][`SA_MAP_OUT_MSB:0]] = 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_out
      // step generator advances on the loop tick
      sa_step_out u_out (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (tick),
        .enable    (out_en[g]),
        .mode_dual (ocfg_reg[g][`SA_CFG_MODE]),
        .pol_low   (ocfg_reg[g][`SA_CFG_POL]),
        .req       (step_req[g]),
        .fwd       (step_fwd[g]),
        .pin_a     (step_a[g]),
        .pin_b     (step_b[g])
      );
    end
  endgenerate

endmodule // sa_top

// ---- tb/sa_chk.sv ----
// checker for sa_top: bus handshakes, tick grid, update and pin timing
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module sa_chk #(
  parameter BASE_CYCLES   = 8,
  parameter LARGE_VARIANT = 0
) (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // axi4-lite
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // core side
  input wire        loop_tick,
  input wire [7:0]  axis_update,
  input wire [7:0]  fb_primary_en,
  input wire [3:0]  step_a,
  input wire [3:0]  step_b
);
  reg [15:0] gap_reg;
  reg        seen_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // cycles since the last tick; the first tick after reset is not judged
  always @(posedge aclk) begin
    gap_reg  <= (!aresetn || loop_tick) ? 16'h0000 : gap_reg + 16'h0001;
    seen_reg <= aresetn && (seen_reg || loop_tick);
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read data");
  a_tick_grid: assert property (loop_tick && seen_reg |-> (gap_reg + 16'h0001) % BASE_CYCLES == 0)
    else $error("tick off the base grid");
  a_update_on_tick: assert property (axis_update != 8'h00 |-> $past(loop_tick))
    else $error("axis update without tick");
  a_update_once: assert property (axis_update != 8'h00 |=> axis_update == 8'h00)
    else $error("axis update longer than one cycle");
  a_pins_on_tick: assert property ($changed(step_a) || $changed(step_b) |->
    $past(loop_tick, 2) || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin moved off tick");
  a_fb_on_write: assert property ($changed(fb_primary_en) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("feedback enable moved without command");
endmodule // sa_chk

bind sa_top sa_chk #(.BASE_CYCLES(BASE_CYCLES), .LARGE_VARIANT(LARGE_VARIANT)) u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .loop_tick, .axis_update,
  .fb_primary_en, .step_a, .step_b);

// ---- tb/sa_drv_model.sv ----
// stepper driver model: net step count seen on each output pair
// assumes the bench tells it each output's mode and polarity
`timescale 1ns/1ps
module sa_drv_model (
  // clock
  input wire       aclk,
  // pins and setup
  input wire [3:0] step_a,
  input wire [3:0] step_b,
  input wire [3:0] mode_dual,
  input wire [3:0] pol_low,
  // net steps per output
  output int       pos [4]
);
  logic [3:0] act_a_q = 4'h0;
  logic [3:0] act_b_q = 4'h0;
  initial pos = '{0, 0, 0, 0};
  always @(posedge aclk) begin
    for (int n = 0; n < 4; n++) begin
      automatic logic aa = step_a[n] ^ pol_low[n];
      automatic logic bb = step_b[n] ^ pol_low[n];
      if (aa && !act_a_q[n])
        pos[n] += (mode_dual[n] || bb) ? 1 : -1;
      if (mode_dual[n] && bb && !act_b_q[n])
        pos[n] -= 1;
      act_a_q[n] = aa;
      act_b_q[n] = bb;
    end
  end
endmodule // sa_drv_model

// ---- tb/sa_top_tb_top.sv ----
// testbench for sa_top: registers over axi4-lite, rate checks, step pins
// assumes the checker binds itself and the driver model watches the pins
`timescale 1ns/1ps
`include "sa_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("unexpected %0t: %h not %h", $time, g, e); end end
module sa_top_tb_top;
  localparam BC = 8;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, loop_tick, f;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, axis_active, axis_update, fb_primary_en, fb_secondary_en;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, step_req, step_fwd, step_a, step_b, m_dual, m_pol;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          mismatches, checked, pos [4], n, e;
  sa_top #(.BASE_CYCLES(BC), .LARGE_VARIANT(0)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .axis_active, .step_req, .step_fwd, .loop_tick, .axis_update, .fb_primary_en,
    .fb_secondary_en, .step_a, .step_b);
  sa_drv_model u_drv (.aclk, .step_a, .step_b, .mode_dual(m_dual), .pol_low(m_pol), .pos);
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    `CHK(s_axi_rdata, d)
    `CHK(s_axi_rresp, r)
  endtask
  task automatic tk;
    do @(posedge aclk); while (!loop_tick);
  endtask
  // failing checks of an enable command, in priority order
  function automatic logic [2:0] exp_err(logic [7:0] bm, logic [2:0] c);
    if (bm & 8'hf4) return 3'h4;
    if (c < $countones(bm) - 1 || (c == 0 && (bm & 8'h03) != 0)) return 3'h1;
    return 3'h0;
  endfunction
  ////////////////////////////////////////
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, axis_active, step_req, step_fwd, m_dual} = 0;
    s_axi_wstrb = 4'hf;
    m_pol = 4'hf;
    n = $urandom(32'h0000_38f6);
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rdc(`SA_OFF_ENABLE, 32'h0000_0300, `SA_RESP_OKAY);
    rdc(8'h40, 32'h0000_0002, `SA_RESP_OKAY);
    rdc(8'hfc, 32'h0000_0000, `SA_RESP_SLVERR);
    wr(8'hfc, 32'h0000_0001, rs);
    `CHK(rs, `SA_RESP_SLVERR)
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wr(`SA_OFF_ENABLE, c << 8, rs);
      tk();
      tk();
      n = 0;
      do begin @(posedge aclk); n++; end while (!loop_tick);
      `CHK(n, (c + 1) * BC)
    end
    $display("test rate done");
    // maps written while all axes are disabled
    wr(8'h20, 32'h0000_000c, rs);
    wr(8'h24, 32'h0000_0018, rs);
    wr(8'h2c, 32'h0000_0008, rs);
    e = 32'h0000_0700;
    for (int i = 0; i < 4; i++) begin
      automatic logic [7:0] bm = (i == 0) ? 8'h04 : (i == 1) ? 8'h02 : (i == 2) ? 8'h01 : 8'h0b;
      automatic logic [2:0] c = (i == 3) ? 3'h1 : 3'h0;
      wr(`SA_OFF_ENABLE, {c, bm}, rs);
      rdc(`SA_OFF_STATUS, {e[10:8], e[7:0], 5'h00, exp_err(bm, c)}, `SA_RESP_OKAY);
      wr(`SA_OFF_STATUS, 32'h0000_0007, rs);
    end
    wr(`SA_OFF_ENABLE, 32'h0000_0008, rs);
    wr(`SA_OFF_ENABLE, 32'h0000_020b, rs);
    rdc(`SA_OFF_STATUS, 32'h0002_0b00, `SA_RESP_OKAY);
    `CHK(fb_primary_en, 8'h0b)
    `CHK(fb_secondary_en, 8'h02)
    tk();
    @(posedge aclk);
    `CHK(axis_update, 8'h0b)
    $display("test enable done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h60, k, rs);
      rdc(8'h40, k, `SA_RESP_OKAY);
      m_dual[0] <= k[0];
      m_pol[0] <= k[1];
      tk();
      tk();
      e = pos[0];
      repeat (3) begin
        f = $urandom;
        step_req <= {3'($urandom), 1'b1};
        step_fwd <= {3'($urandom), f};
        tk();
        step_req <= 4'h0;
        tk();
        tk();
        e += f ? 1 : -1;
        `CHK(pos[0], e)
        `CHK(step_a, {3'h7, k[1]})
        `CHK(step_b[0], k[0] ? k[1] : f ^ k[1])
      end
    end
    $display("test steps done");
    axis_active <= 8'h01;
    wr(`SA_OFF_ENABLE, 32'h0000_020a, rs);
    rdc(`SA_OFF_STATUS, 32'h0002_0b02, `SA_RESP_OKAY);
    axis_active <= 8'h00;
    wr(`SA_OFF_ENABLE, 32'h0000_020a, rs);
    rdc(`SA_OFF_ENABLE, 32'h0000_020a, `SA_RESP_OKAY);
    $display("test kill done");
    finish_test();
  end
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    finish_test();
  end
endmodule // sa_top_tb_top
